// ==== pkg/llem_pkg.sv ====
package llem_pkg;

    // Bank shape: four counters fed, three header slots per flit
    localparam int LLEM_NCTR  = 4;
    localparam int LLEM_NSLOT = 3;

    // Event select codes
    localparam logic [7:0] LLEM_EV_RX_ALLOC  = 8'h30;
    localparam logic [7:0] LLEM_EV_RX_OCC    = 8'h32;
    localparam logic [7:0] LLEM_EV_TX_HALF   = 8'h27;
    localparam logic [7:0] LLEM_EV_TX_ACTIVE = 8'h26;
    localparam logic [7:0] LLEM_EV_TX_HDR    = 8'h04;
    localparam logic [7:0] LLEM_EV_TX_BYPASS = 8'h41;

    // Largest increment each event may present in one cycle
    localparam logic [7:0] LLEM_MAX_RX_ALLOC = 8'h03;
    localparam logic [7:0] LLEM_MAX_RX_OCC   = 8'h80;
    localparam logic [7:0] LLEM_MAX_HDR      = 8'h03;
    localparam logic [7:0] LLEM_MAX_ONE      = 8'h01;

    // Value of every increment output after reset
    localparam logic [7:0] LLEM_INC_RST = 8'h00;

    // Unit mask fields (mask bits 15:8 of the control word, here 7:0)
    localparam int LLEM_UM_SLOT_LSB  = 0;
    localparam int LLEM_UM_CLASS_LSB = 0;
    localparam int LLEM_UM_CLASS_EN  = 3;
    localparam int LLEM_UM_OPC_LSB   = 4;

    // Extension fields (control word bits 55:32, here 23:0)
    localparam int LLEM_XT_OPC_EN   = 0;
    localparam int LLEM_XT_SLOT_LSB = 1;
    localparam int LLEM_XT_LOC_EN   = 4;
    localparam int LLEM_XT_LOC_VAL  = 5;
    localparam int LLEM_XT_DATA_EN  = 6;
    localparam int LLEM_XT_DATA_VAL = 7;
    localparam int LLEM_XT_DUAL_EN  = 8;
    localparam int LLEM_XT_DUAL_VAL = 9;

    // Message class codes
    localparam logic [3:0] LLEM_CLS_REQ    = 4'h8;
    localparam logic [3:0] LLEM_CLS_SNP    = 4'h9;
    localparam logic [3:0] LLEM_CLS_RSP_ND = 4'ha;
    localparam logic [3:0] LLEM_CLS_RSP_D  = 4'hc;
    localparam logic [3:0] LLEM_CLS_WB     = 4'hd;
    localparam logic [3:0] LLEM_CLS_NCB    = 4'he;
    localparam logic [3:0] LLEM_CLS_NCS    = 4'hf;

    // Transmit link power state, Gray along train-active-half-sleep
    typedef enum logic [1:0]
    {
        LLEM_LINK_TRAIN  = 2'h0,
        LLEM_LINK_ACTIVE = 2'h1,
        LLEM_LINK_HALF   = 2'h3,
        LLEM_LINK_SLEEP  = 2'h2
    } llem_link_e;

    typedef struct packed
    {
        logic       valid;
        logic [3:0] msg_class;
        logic [3:0] opcode;
        logic       is_local;
        logic       is_data;
        logic       is_dual;
    } llem_hdr_s;

    typedef logic [7:0] llem_inc_t;
    typedef logic [6:0] llem_occ_t;

    function automatic logic [1:0] llem_pop3(input logic [2:0] v);
        llem_pop3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    endfunction : llem_pop3

    function automatic logic llem_class_known(input logic [3:0] c);
        llem_class_known = (c == LLEM_CLS_REQ) || (c == LLEM_CLS_SNP)
            || (c == LLEM_CLS_RSP_ND) || (c == LLEM_CLS_RSP_D)
            || (c == LLEM_CLS_WB) || (c == LLEM_CLS_NCB)
            || (c == LLEM_CLS_NCS);
    endfunction : llem_class_known

endpackage : llem_pkg

// ==== pkg/llem_hdr_if.sv ====
`timescale 1ns/100ps
interface llem_hdr_if;
    import llem_pkg::*;
    llem_hdr_s   hdr [LLEM_NSLOT];
    logic [7:0]  umask;
    logic [23:0] ext;
    logic [1:0]  match_cnt;

    modport mon
    (
        input  hdr,
        input  umask,
        input  ext,
        output match_cnt
    );
    modport top
    (
        output hdr,
        output umask,
        output ext,
        input  match_cnt
    );
endinterface : llem_hdr_if

// ==== rtl/llem_hdr_match.sv ====
`timescale 1ns/100ps
module llem_hdr_match
(
    llem_hdr_if.mon bus
);
    import llem_pkg::*;

    logic [LLEM_NSLOT-1:0] slot_hit;

    // Each slot ANDs its enabled filter terms; slots then combine
    always_comb
    begin
        for (int s = 0; s < LLEM_NSLOT; s++)
        begin
            slot_hit[s] = bus.hdr[s].valid
                && bus.ext[LLEM_XT_SLOT_LSB + s]
                && (!bus.umask[LLEM_UM_CLASS_EN]
                    || (llem_class_known(bus.hdr[s].msg_class)
                    && bus.hdr[s].msg_class
                       == bus.umask[LLEM_UM_CLASS_LSB +: 4]))  // see RULE12
                && (!bus.ext[LLEM_XT_OPC_EN]
                    || bus.hdr[s].opcode
                       == bus.umask[LLEM_UM_OPC_LSB +: 4])     // see RULE12
                && (!bus.ext[LLEM_XT_LOC_EN]
                    || bus.hdr[s].is_local == bus.ext[LLEM_XT_LOC_VAL])
                && (!bus.ext[LLEM_XT_DATA_EN]
                    || bus.hdr[s].is_data == bus.ext[LLEM_XT_DATA_VAL])
                && (!bus.ext[LLEM_XT_DUAL_EN]
                    || bus.hdr[s].is_dual == bus.ext[LLEM_XT_DUAL_VAL]);
        end
        bus.match_cnt = llem_pop3(slot_hit); // see RULE11
    end

endmodule : llem_hdr_match

// ==== rtl/llem_top.sv ====
`timescale 1ns/100ps
// How it works
// RULE1: Code 0x30 counts receive queue allocations, slots 0-2 by mask, max 3.
// RULE2: A receive slot allocates only when ring forwarding is backed up.
// RULE3: Code 0x32 adds masked receive queue occupancy, saturating at 128.
// RULE4: Code 0x27 counts one per cycle the transmit side is half-width.
// RULE5: Edge detect turns power residency into one count per state entry.
// RULE6: Sleep residency flags edge-detected power counts as unreliable.
// RULE7: Transmit power state is tracked on its own, apart from receive.
// RULE8: Code 0x26 counts active cycles, half-width cycles included.
// RULE9: Cycles spent in link training are excluded from active residency.
// RULE10: Code 0x04 counts header matches, max 3, filtered by extension bits.
// RULE11: Header filter terms AND within a slot, then slots combine.
// RULE12: Low mask nibble picks message class; extension bit 0 adds opcode.
// RULE13: Code 0x41 counts one per flit that skips the transmit queue.
// RULE14: Half-width or link retry forces transmit flits through the queue.
// RULE15: Unselected or idle events present zero, never above their maximum.
module llem_top
    import llem_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic [7:0]                 evt_sel [llem_pkg::LLEM_NCTR],
    input  wire logic [7:0]                 umask [llem_pkg::LLEM_NCTR],
    input  wire logic [23:0]                umask_ext [llem_pkg::LLEM_NCTR],
    input  wire logic [3:0]                 edge_det,
    input  wire logic [2:0]                 rx_slot_flit,
    input  wire logic                       rx_ring_backed_up,
    input  wire llem_pkg::llem_occ_t        rx_occ [llem_pkg::LLEM_NSLOT],
    input  wire llem_pkg::llem_link_e       tx_state,
    input  wire llem_pkg::llem_link_e       rx_state,
    input  wire logic                       tx_retry,
    input  wire logic                       tx_flit_valid,
    input  wire llem_pkg::llem_hdr_s        tx_hdr [llem_pkg::LLEM_NSLOT],
    input  wire logic                       unreliable_clr,
    output logic [2:0]                      rx_alloc,
    output logic                            tx_route_queue,
    output logic                            rx_half_width,
    output logic                            edge_unreliable,
    output llem_pkg::llem_inc_t             inc [llem_pkg::LLEM_NCTR]
);
    import llem_pkg::*;

    llem_inc_t  inc_reg [LLEM_NCTR];
    llem_inc_t  inc_next [LLEM_NCTR];
    logic       tx_act_prev_reg;
    logic       tx_act_prev_next;
    logic       tx_half_prev_reg;
    logic       tx_half_prev_next;
    logic       unrel_reg;
    logic       unrel_next;
    logic       tx_in_active;
    logic       tx_in_half;
    logic       tx_bypass;
    logic [1:0] hdr_cnt [LLEM_NCTR];

    // One filter per counter, since each counter has its own mask
    genvar g;
    generate
        for (g = 0; g < LLEM_NCTR; g++)
        begin : g_hdr
            llem_hdr_if hif ();
            assign hif.hdr   = tx_hdr;
            assign hif.umask = umask[g];
            assign hif.ext   = umask_ext[g];
            assign hdr_cnt[g] = hif.match_cnt;
            llem_hdr_match u_match
            (
                .bus (hif.mon)
            );
        end
    endgenerate

    // Bypass is the common case; queueing only when the ring stalls
    assign rx_alloc = rx_ring_backed_up ? rx_slot_flit : 3'h0; // see RULE2

    // Half-width and retry both need replay storage, so no bypass
    assign tx_route_queue = (tx_state == LLEM_LINK_HALF) || tx_retry; // see RULE14
    assign tx_bypass      = tx_flit_valid && !tx_route_queue;       // see RULE13

    // Receive direction only reported, never mixed into transmit counts
    assign rx_half_width = (rx_state == LLEM_LINK_HALF); // see RULE7

    // Training drops out of active; half-width still counts as active
    assign tx_in_half   = (tx_state == LLEM_LINK_HALF);   // see RULE4
    assign tx_in_active = (tx_state == LLEM_LINK_ACTIVE)
                       || tx_in_half;                     // see RULE8, RULE9

    assign edge_unreliable = unrel_reg;
    assign inc             = inc_reg;

    // Per-counter increment selection
    always_comb
    begin
        logic [8:0] occ_sum;
        occ_sum = 9'h000;
        for (int s = 0; s < LLEM_NSLOT; s++)
        begin
            if (umask[0][LLEM_UM_SLOT_LSB + s])
            begin
                occ_sum = occ_sum + {2'b00, rx_occ[s]};
            end
        end
        for (int c = 0; c < LLEM_NCTR; c++)
        begin
            occ_sum = 9'h000;
            for (int s = 0; s < LLEM_NSLOT; s++)
            begin
                if (umask[c][LLEM_UM_SLOT_LSB + s])
                begin
                    occ_sum = occ_sum + {2'b00, rx_occ[s]}; // see RULE3
                end
            end
            case (evt_sel[c])
                LLEM_EV_RX_ALLOC:
                    inc_next[c] = {6'h00, llem_pop3(rx_alloc
                        & umask[c][LLEM_UM_SLOT_LSB +: 3])};    // see RULE1
                LLEM_EV_RX_OCC:
                    // Saturate: the counter side cannot take more per cycle
                    inc_next[c] = (occ_sum > {1'b0, LLEM_MAX_RX_OCC})
                        ? LLEM_MAX_RX_OCC : occ_sum[7:0];       // see RULE3, RULE15
                LLEM_EV_TX_HALF:
                    inc_next[c] = {7'h00, edge_det[c]
                        ? (tx_in_half && !tx_half_prev_reg)
                        : tx_in_half};                          // see RULE4, RULE5
                LLEM_EV_TX_ACTIVE:
                    inc_next[c] = {7'h00, edge_det[c]
                        ? (tx_in_active && !tx_act_prev_reg)
                        : tx_in_active};                        // see RULE8, RULE5
                LLEM_EV_TX_HDR:
                    inc_next[c] = {6'h00, hdr_cnt[c]};          // see RULE10
                LLEM_EV_TX_BYPASS:
                    inc_next[c] = {7'h00, tx_bypass};           // see RULE13
                default:
                    inc_next[c] = LLEM_INC_RST;                 // see RULE15
            endcase
        end
    end

    // History for edge detect and the sticky unreliability flag
    always_comb
    begin
        tx_act_prev_next  = tx_in_active;
        tx_half_prev_next = tx_in_half;
        // Set wins over a clear arriving in the same cycle
        unrel_next = (tx_state == LLEM_LINK_SLEEP)
                  || (unrel_reg && !unreliable_clr);            // see RULE6
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int c = 0; c < LLEM_NCTR; c++)
            begin
                inc_reg[c] <= LLEM_INC_RST;
            end
            tx_act_prev_reg  <= 1'b0;
            tx_half_prev_reg <= 1'b0;
            unrel_reg        <= 1'b0;
        end
        else if (ce)
        begin
            inc_reg          <= inc_next;
            tx_act_prev_reg  <= tx_act_prev_next;
            tx_half_prev_reg <= tx_half_prev_next;
            unrel_reg        <= unrel_next;
        end
    end

    // Checks on counter 0 after a cycle with clock enable high, and on rx_alloc and edge_unreliable
    a_alloc_slots: assert property (@(posedge clk) disable iff (rst) // see RULE1
        ce && evt_sel[0] == LLEM_EV_RX_ALLOC
        |=> inc_reg[0] == {6'h00, llem_pop3($past(rx_alloc)
            & $past(umask[0][2:0]))})
        else $error("alloc increment wrong");

    a_alloc_stall: assert property (@(posedge clk) disable iff (rst) // see RULE2
        !rx_ring_backed_up |-> rx_alloc == 3'h0)
        else $error("allocation without ring backup");

    // Three slots of at least 64 each must clip to the per-cycle maximum
    a_occ_capped: assert property (@(posedge clk) disable iff (rst) // see RULE3
        ce && evt_sel[0] == LLEM_EV_RX_OCC && umask[0][2:0] == 3'h7
        && rx_occ[0][6] && rx_occ[1][6] && rx_occ[2][6]
        |=> inc_reg[0] == LLEM_MAX_RX_OCC)
        else $error("occupancy not saturated at 128");

    a_half_level: assert property (@(posedge clk) disable iff (rst) // see RULE4
        ce && evt_sel[0] == LLEM_EV_TX_HALF && !edge_det[0]
        |=> inc_reg[0] == {7'h00, $past(tx_state) == LLEM_LINK_HALF})
        else $error("half-width residency wrong");

    a_half_edge: assert property (@(posedge clk) disable iff (rst) // see RULE5
        ce && evt_sel[0] == LLEM_EV_TX_HALF && edge_det[0]
        && tx_state == LLEM_LINK_HALF ##1 ce && evt_sel[0] == LLEM_EV_TX_HALF
        && edge_det[0] && tx_state == LLEM_LINK_HALF
        |=> inc_reg[0] == 8'h00)
        else $error("edge count repeated in state");

    a_unrel_sticky: assert property (@(posedge clk) disable iff (rst) // see RULE6
        ce && tx_state == LLEM_LINK_SLEEP |=> edge_unreliable)
        else $error("sleep not flagged");

    a_active_train: assert property (@(posedge clk) disable iff (rst) // see RULE9
        ce && evt_sel[0] == LLEM_EV_TX_ACTIVE
        && tx_state == LLEM_LINK_TRAIN |=> inc_reg[0] == 8'h00)
        else $error("training counted as active");

    a_active_half: assert property (@(posedge clk) disable iff (rst) // see RULE8
        ce && evt_sel[0] == LLEM_EV_TX_ACTIVE && !edge_det[0]
        && tx_state == LLEM_LINK_HALF |=> inc_reg[0] == 8'h01)
        else $error("half-width not in active count");

    a_hdr_max: assert property (@(posedge clk) disable iff (rst) // see RULE10
        ce && evt_sel[0] == LLEM_EV_TX_HDR |=> inc_reg[0] <= LLEM_MAX_HDR)
        else $error("header increment above 3");

    a_bypass_block: assert property (@(posedge clk) disable iff (rst) // see RULE14
        ce && evt_sel[0] == LLEM_EV_TX_BYPASS
        && (tx_state == LLEM_LINK_HALF || tx_retry) |=> inc_reg[0] == 8'h00)
        else $error("bypass during half-width or retry");

    a_unknown_zero: assert property (@(posedge clk) disable iff (rst) // see RULE15
        ce && evt_sel[0] == 8'h00 |=> inc_reg[0] == LLEM_INC_RST)
        else $error("unselected event not zero");

endmodule : llem_top

// ==== tb/llem_top_bench.sv ====
`timescale 1ns/100ps
module llem_top_bench;
    import llem_pkg::*;
    logic        clk;
    logic        rst;
    logic        ce;
    logic [7:0]  evt_sel [LLEM_NCTR];
    logic [7:0]  umask [LLEM_NCTR];
    logic [23:0] umask_ext [LLEM_NCTR];
    logic [3:0]  edge_det;
    logic [2:0]  rx_slot_flit;
    logic        rx_ring_backed_up;
    llem_occ_t   rx_occ [LLEM_NSLOT];
    llem_link_e  tx_state;
    llem_link_e  rx_state;
    logic        tx_retry;
    logic        tx_flit_valid;
    llem_hdr_s   tx_hdr [LLEM_NSLOT];
    logic        unreliable_clr;
    logic [2:0]  rx_alloc;
    logic        tx_route_queue;
    logic        rx_half_width;
    logic        edge_unreliable;
    llem_inc_t   inc [LLEM_NCTR];
    int          err_total;
    int          checked;
    logic [3:0]  cls_tab [7];

    llem_top uut
    (
        .clk               (clk),
        .rst               (rst),
        .ce                (ce),
        .evt_sel           (evt_sel),
        .umask             (umask),
        .umask_ext         (umask_ext),
        .edge_det          (edge_det),
        .rx_slot_flit      (rx_slot_flit),
        .rx_ring_backed_up (rx_ring_backed_up),
        .rx_occ            (rx_occ),
        .tx_state          (tx_state),
        .rx_state          (rx_state),
        .tx_retry          (tx_retry),
        .tx_flit_valid     (tx_flit_valid),
        .tx_hdr            (tx_hdr),
        .unreliable_clr    (unreliable_clr),
        .rx_alloc          (rx_alloc),
        .tx_route_queue    (tx_route_queue),
        .rx_half_width     (rx_half_width),
        .edge_unreliable   (edge_unreliable),
        .inc               (inc)
    );

    // Free-running 50 MHz clock
    always #10 clk = ~clk;

    // Compare, count, and report a mismatch at once
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Inputs change 1 ns after an edge, so the next edge samples them
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    // Program one counter's event, masks and edge detect
    task automatic cfg(input int c, input logic [7:0] sel,
                       input logic [7:0] um, input logic [23:0] xt,
                       input logic ed);
        evt_sel[c]   = sel;
        umask[c]     = um;
        umask_ext[c] = xt;
        edge_det[c]  = ed;
    endtask : cfg

    // Load the same header into all three slots
    task automatic hdr3(input logic [3:0] cls, input logic [3:0] opc,
                        input logic [2:0] flg);
        for (int s = 0; s < LLEM_NSLOT; s++)
            tx_hdr[s] = {1'b1, cls, opc, flg};
    endtask : hdr3

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // Watchdog: the sequence needs about 1.2 us
    initial
    begin
        #20000;
        err_total++;
        print_verdict();
    end

    // Main test sequence
    initial
    begin
        cls_tab = '{LLEM_CLS_REQ, LLEM_CLS_SNP, LLEM_CLS_RSP_ND,
                    LLEM_CLS_RSP_D, LLEM_CLS_WB, LLEM_CLS_NCB, LLEM_CLS_NCS};
        err_total = 0;
        checked = 0;
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        for (int c = 0; c < LLEM_NCTR; c++)
            cfg(c, 8'h00, 8'h00, 24'h000000, 1'b0);
        rx_slot_flit = 3'h0;
        rx_ring_backed_up = 1'b0;
        rx_occ = '{7'h00, 7'h00, 7'h00};
        tx_state = LLEM_LINK_TRAIN;
        rx_state = LLEM_LINK_TRAIN;
        tx_retry = 1'b0;
        tx_flit_valid = 1'b0;
        hdr3(4'h0, 4'h0, 3'h0);
        unreliable_clr = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        for (int c = 0; c < LLEM_NCTR; c++)
            chk(inc[c], LLEM_INC_RST);
        chk({7'h00, edge_unreliable}, 8'h00);
        $display("test reset done");
        // Allocation only while ring forwarding is backed up
        cfg(1, LLEM_EV_RX_ALLOC, 8'h05, 24'h000000, 1'b0);
        rx_slot_flit = 3'h7;
        rx_ring_backed_up = 1'b1;
        #1 chk({5'h00, rx_alloc}, 8'h07);
        tick();
        chk(inc[1], 8'h02);
        chk(inc[0], 8'h00);
        umask[1] = 8'h07;
        tick();
        chk(inc[1], LLEM_MAX_RX_ALLOC);
        rx_ring_backed_up = 1'b0;
        tick();
        chk(inc[1], 8'h00);
        chk({5'h00, rx_alloc}, 8'h00);
        $display("test alloc done");
        // Occupancy sum saturates at its per-cycle maximum
        cfg(2, LLEM_EV_RX_OCC, 8'h07, 24'h000000, 1'b0);
        rx_occ = '{7'h64, 7'h64, 7'h64};
        tick();
        chk(inc[2], LLEM_MAX_RX_OCC);
        umask[2] = 8'h02;
        tick();
        chk(inc[2], 8'h64);
        evt_sel[2] = 8'h55;
        tick();
        chk(inc[2], 8'h00);
        $display("test occupancy done");
        // Residency counts follow the transmit state only
        cfg(3, LLEM_EV_TX_HALF, 8'h00, 24'h000000, 1'b0);
        tx_state = LLEM_LINK_HALF;
        rx_state = LLEM_LINK_ACTIVE;
        tick();
        chk(inc[3], 8'h01);
        chk({7'h00, rx_half_width}, 8'h00);
        tx_state = LLEM_LINK_ACTIVE;
        rx_state = LLEM_LINK_HALF;
        tick();
        chk(inc[3], 8'h00);
        chk({7'h00, rx_half_width}, 8'h01);
        evt_sel[3] = LLEM_EV_TX_ACTIVE;
        tx_state = LLEM_LINK_HALF;
        tick();
        chk(inc[3], 8'h01);
        tx_state = LLEM_LINK_TRAIN;
        tick();
        chk(inc[3], 8'h00);
        $display("test residency done");
        // Edge detect counts entries, not cycles spent
        cfg(0, LLEM_EV_TX_ACTIVE, 8'h00, 24'h000000, 1'b1);
        tick();
        tx_state = LLEM_LINK_ACTIVE;
        tick();
        chk(inc[0], 8'h01);
        tick();
        chk(inc[0], 8'h00);
        evt_sel[0] = LLEM_EV_TX_HALF;
        tx_state = LLEM_LINK_HALF;
        tick();
        chk(inc[0], 8'h01);
        ce = 1'b0;
        tick();
        chk(inc[0], 8'h01);
        ce = 1'b1;
        edge_det[0] = 1'b0;
        $display("test edge done");
        // Sleep marks edge counts unreliable; set beats clear
        tx_state = LLEM_LINK_SLEEP;
        tick();
        chk({7'h00, edge_unreliable}, 8'h01);
        unreliable_clr = 1'b1;
        tick();
        chk({7'h00, edge_unreliable}, 8'h01);
        tx_state = LLEM_LINK_ACTIVE;
        tick();
        chk({7'h00, edge_unreliable}, 8'h00);
        unreliable_clr = 1'b0;
        $display("test sleep done");
        // Bypass only when neither half width nor retry
        cfg(1, LLEM_EV_TX_BYPASS, 8'h00, 24'h000000, 1'b0);
        tx_flit_valid = 1'b1;
        tick();
        chk(inc[1], LLEM_MAX_ONE);
        chk({7'h00, tx_route_queue}, 8'h00);
        tx_retry = 1'b1;
        tick();
        chk(inc[1], 8'h00);
        chk({7'h00, tx_route_queue}, 8'h01);
        tx_retry = 1'b0;
        tx_state = LLEM_LINK_HALF;
        tick();
        chk(inc[1], 8'h00);
        chk({7'h00, tx_route_queue}, 8'h01);
        $display("test bypass done");
        // Every message class, all three slots enabled
        for (int k = 0; k < 7; k++)
        begin
            cfg(2, LLEM_EV_TX_HDR, {4'h0, cls_tab[k]}, 24'h00000e, 1'b0);
            hdr3(cls_tab[k], 4'h0, 3'h0);
            tick();
            chk(inc[2], LLEM_MAX_HDR);
        end
        tx_hdr[2] = {1'b1, LLEM_CLS_SNP, 4'h0, 3'h0};
        tick();
        chk(inc[2], 8'h02);
        cfg(2, LLEM_EV_TX_HDR, 8'h0b, 24'h00000e, 1'b0);
        hdr3(4'hb, 4'h0, 3'h0);
        tick();
        chk(inc[2], 8'h00);
        // Slot enables, locality term, opcode match
        cfg(2, LLEM_EV_TX_HDR, 8'h08, 24'h000002, 1'b0);
        hdr3(LLEM_CLS_REQ, 4'h0, 3'h0);
        tick();
        chk(inc[2], 8'h01);
        umask_ext[2] = 24'h00003e;
        tx_hdr[1] = {1'b1, LLEM_CLS_REQ, 4'h0, 3'h4};
        tick();
        chk(inc[2], 8'h01);
        cfg(2, LLEM_EV_TX_HDR, 8'h2a, 24'h00000f, 1'b0);
        hdr3(LLEM_CLS_RSP_ND, 4'h2, 3'h0);
        tx_hdr[1] = {1'b1, LLEM_CLS_RSP_ND, 4'h3, 3'h0};
        tick();
        chk(inc[2], 8'h02);
        $display("test header done");
        // Counter 0 walks the checked events in turn
        cfg(0, LLEM_EV_TX_HALF, 8'h00, 24'h000000, 1'b1);
        tick();
        chk(inc[0], 8'h00);
        tick();
        chk(inc[0], 8'h00);
        cfg(0, LLEM_EV_TX_ACTIVE, 8'h00, 24'h000000, 1'b0);
        tick();
        chk(inc[0], 8'h01);
        cfg(0, LLEM_EV_TX_BYPASS, 8'h00, 24'h000000, 1'b0);
        tick();
        chk(inc[0], 8'h00);
        cfg(0, LLEM_EV_TX_HDR, 8'h2a, 24'h00000f, 1'b0);
        tick();
        chk(inc[0], 8'h02);
        // Class filter off; data and dual terms leave slot 0 only
        cfg(0, LLEM_EV_TX_HDR, 8'h00, 24'h0001ce, 1'b0);
        tx_hdr[0] = {1'b1, LLEM_CLS_REQ, 4'h0, 3'h2};
        tx_hdr[1] = {1'b1, LLEM_CLS_REQ, 4'h0, 3'h3};
        tx_hdr[2] = {1'b1, LLEM_CLS_REQ, 4'h0, 3'h0};
        tick();
        chk(inc[0], 8'h01);
        cfg(0, LLEM_EV_RX_OCC, 8'h07, 24'h000000, 1'b0);
        tick();
        chk(inc[0], LLEM_MAX_RX_OCC);
        cfg(0, LLEM_EV_RX_ALLOC, 8'h03, 24'h000000, 1'b0);
        rx_ring_backed_up = 1'b1;
        tick();
        chk(inc[0], 8'h02);
        evt_sel[0] = 8'h00;
        tick();
        chk(inc[0], LLEM_INC_RST);
        $display("test counter0 done");
        print_verdict();
    end
endmodule : llem_top_bench
